// ---- hdl/dwm_pkg.sv ----
// constants and carrier types for the droop wake monitor control logic
package dwm_pkg;
  localparam int CLK_PERIOD_NS = 40;
  // winding-sense low time before arming (least time, rounds up)
  localparam int DETECT_LOW_MIN_NS = 500;
  localparam int DETECT_LOW_CYC_I = (DETECT_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DETECT_LOW_CYC = 4'(DETECT_LOW_CYC_I);
  localparam logic [3:0] LOW_CNT_MAX = 4'hf;
  // wake pulse width and repeat period
  localparam int WAKE_PULSE_NS = 1000;
  localparam int WAKE_PULSE_CYC_I = WAKE_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [9:0] WAKE_PULSE_CYC = 10'(WAKE_PULSE_CYC_I);
  localparam int WAKE_RATE_HZ = 33000;
  localparam int WAKE_PERIOD_NS = 1000000000 / WAKE_RATE_HZ;
  localparam int WAKE_PERIOD_CYC_I = WAKE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [9:0] WAKE_PERIOD_LAST = 10'(WAKE_PERIOD_CYC_I - 1);
  localparam logic [9:0] OSC_CNT_MAX = 10'h3ff;
  // switching period thresholds
  localparam int DISABLE_PERIOD_NS = 177000;
  localparam int DISABLE_PERIOD_CYC_I = DISABLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ENABLE_PERIOD_NS = 57000;
  localparam int ENABLE_PERIOD_CYC_I = ENABLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] PERIOD_CNT_MAX = 16'hffff;
  // cycle counts for the enable output
  localparam logic [5:0] DISABLE_COUNT = 6'h3f;
  localparam logic [5:0] ENABLE_COUNT = 6'h20;
  localparam logic [5:0] CYCLE_CNT_MAX = 6'h3f;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic {ARM_IDLE = 1'b0, ARM_READY = 1'b1} dwm_arm_e;
  typedef enum logic {WAKE_IDLE = 1'b0, WAKE_ACTIVE = 1'b1} dwm_wake_e;
  typedef enum logic {ENS_RELEASED = 1'b0, ENS_PULLED = 1'b1} dwm_ens_e;

  typedef struct packed {
    logic wake_out;
    logic wake_oe;
    logic ens_out;
    logic ens_oe;
    logic sample_cmd;
  } dwm_pins_s;

  localparam dwm_pins_s PINS_RESET = '{default: 1'b0};
endpackage : dwm_pkg

// ---- hdl/dwm_sat_cnt.sv ----
// saturating up-counter with synchronous clear
`timescale 1ns/100ps
module dwm_sat_cnt #(
  parameter int W = 8,
  parameter logic [W-1:0] MAX = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic inc,
  output logic [W-1:0] cnt
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = '0;
    end else if (inc && cnt_r != MAX) begin
      cnt_nxt = W'(cnt_r + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt = cnt_r;
endmodule : dwm_sat_cnt

// ---- hdl/dwm_ctrl.sv ----
// control logic of the secondary-side droop wake monitor
`timescale 1ns/100ps
module dwm_ctrl #(
  parameter logic [15:0] DISABLE_PERIOD_CYC = 16'(dwm_pkg::DISABLE_PERIOD_CYC_I)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wake_in,
  input wire logic droop_fired,
  input wire logic supply_lockout,
  output dwm_pkg::dwm_pins_s pins
);
  localparam logic [15:0] ENABLE_PERIOD_CYC = 16'(dwm_pkg::ENABLE_PERIOD_CYC_I);

  // two-stage synchronisers: bit 0 sense, bit 1 droop, bit 2 lockout
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sense_s;
  logic droop_s;
  logic active;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= dwm_pkg::SYNC_RESET;
      sync2_r <= dwm_pkg::SYNC_RESET;
    end else begin
      sync1_r <= {supply_lockout, droop_fired, wake_in};
      sync2_r <= sync1_r;
    end
  end

  assign sense_s = sync2_r[0];
  assign droop_s = sync2_r[1];
  assign active = !sync2_r[2];

  // state
  dwm_pkg::dwm_arm_e arm_r, arm_nxt;
  dwm_pkg::dwm_wake_e wake_r, wake_nxt;
  dwm_pkg::dwm_ens_e ens_r, ens_nxt;
  logic det_r, det_nxt;
  dwm_pkg::dwm_pins_s pins_r, pins_nxt;

  logic [3:0] low_cnt;
  logic [15:0] per_cnt;
  logic [5:0] long_cnt;
  logic [5:0] short_cnt;
  logic [9:0] osc_cnt;
  logic long_per;
  logic short_per;
  logic osc_wrap;

  // period is judged at the detect pulse that ends it; the count lags the
  // period by one because its clear lands the cycle after the detect
  assign long_per = per_cnt >= DISABLE_PERIOD_CYC;
  assign short_per = per_cnt < ENABLE_PERIOD_CYC - 16'h1;
  assign osc_wrap = osc_cnt == dwm_pkg::WAKE_PERIOD_LAST;

  dwm_sat_cnt #(.W(4), .MAX(dwm_pkg::LOW_CNT_MAX)) u_low_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clr(sense_s || !active),
    .inc(1'b1),
    .cnt(low_cnt)
  );

  // saturation keeps very long gaps reading as long periods
  dwm_sat_cnt #(.W(16), .MAX(dwm_pkg::PERIOD_CNT_MAX)) u_per_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clr(det_r),
    .inc(active),
    .cnt(per_cnt)
  );

  dwm_sat_cnt #(.W(6), .MAX(dwm_pkg::CYCLE_CNT_MAX)) u_long_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clr(ens_r == dwm_pkg::ENS_PULLED || (det_r && !long_per)),
    .inc(det_r && long_per && active),
    .cnt(long_cnt)
  );

  // cumulative: a long period between short ones does not clear it
  dwm_sat_cnt #(.W(6), .MAX(dwm_pkg::CYCLE_CNT_MAX)) u_short_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clr(ens_r == dwm_pkg::ENS_RELEASED),
    .inc(det_r && short_per && active),
    .cnt(short_cnt)
  );

  dwm_sat_cnt #(.W(10), .MAX(dwm_pkg::OSC_CNT_MAX)) u_osc_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clr(det_r || wake_r == dwm_pkg::WAKE_IDLE || osc_wrap),
    .inc(1'b1),
    .cnt(osc_cnt)
  );

  always_comb begin
    arm_nxt = arm_r;
    det_nxt = 1'b0;
    unique case (arm_r)
      dwm_pkg::ARM_IDLE: begin
        if (active && !sense_s && low_cnt >= dwm_pkg::DETECT_LOW_CYC) begin
          arm_nxt = dwm_pkg::ARM_READY;
        end
      end
      dwm_pkg::ARM_READY: begin
        if (sense_s) begin
          arm_nxt = dwm_pkg::ARM_IDLE;
          det_nxt = active;
        end
      end
    endcase
    if (!active) begin
      arm_nxt = dwm_pkg::ARM_IDLE;
    end
  end

  always_comb begin
    wake_nxt = wake_r;
    unique case (wake_r)
      dwm_pkg::WAKE_IDLE: begin
        if (droop_s) begin
          wake_nxt = dwm_pkg::WAKE_ACTIVE;
        end
      end
      dwm_pkg::WAKE_ACTIVE: begin
        // a droop still present at the detect pulse keeps pulsing
        if (det_r && !droop_s) begin
          wake_nxt = dwm_pkg::WAKE_IDLE;
        end
      end
    endcase
    if (!active) begin
      wake_nxt = dwm_pkg::WAKE_IDLE;
    end
  end

  always_comb begin
    ens_nxt = ens_r;
    if (active) begin
      unique case (ens_r)
        dwm_pkg::ENS_RELEASED: begin
          if (long_cnt >= dwm_pkg::DISABLE_COUNT) begin
            ens_nxt = dwm_pkg::ENS_PULLED;
          end
        end
        dwm_pkg::ENS_PULLED: begin
          if (short_cnt >= dwm_pkg::ENABLE_COUNT) begin
            ens_nxt = dwm_pkg::ENS_RELEASED;
          end
        end
      endcase
    end
  end

  always_comb begin
    pins_nxt = dwm_pkg::PINS_RESET;
    pins_nxt.wake_out = 1'b0;
    pins_nxt.ens_out = 1'b0;
    pins_nxt.ens_oe = ens_nxt == dwm_pkg::ENS_PULLED;
    pins_nxt.sample_cmd = det_nxt;
    pins_nxt.wake_oe = active && wake_r == dwm_pkg::WAKE_ACTIVE && !det_r && !osc_wrap
                       && osc_cnt < dwm_pkg::WAKE_PULSE_CYC;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_r <= dwm_pkg::ARM_IDLE;
      wake_r <= dwm_pkg::WAKE_IDLE;
      ens_r <= dwm_pkg::ENS_RELEASED;
      det_r <= 1'b0;
      pins_r <= dwm_pkg::PINS_RESET;
    end else begin
      arm_r <= arm_nxt;
      wake_r <= wake_nxt;
      ens_r <= ens_nxt;
      det_r <= det_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign pins = pins_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ens_pull;
    active && ens_r == dwm_pkg::ENS_RELEASED && long_cnt == dwm_pkg::DISABLE_COUNT |=> pins_r.ens_oe;
  endproperty
  a_ens_pull: assert property (p_ens_pull) else $error("enable not pulled after long count");

  property p_ens_release;
    active && ens_r == dwm_pkg::ENS_PULLED && short_cnt == dwm_pkg::ENABLE_COUNT |=> !pins_r.ens_oe;
  endproperty
  a_ens_release: assert property (p_ens_release) else $error("enable not released after short count");

  property p_ens_cause;
    $rose(pins_r.ens_oe) |-> $past(long_cnt) == dwm_pkg::DISABLE_COUNT && !pins_r.ens_out;
  endproperty
  a_ens_cause: assert property (p_ens_cause) else $error("enable pulled without long count");

  property p_arm_time;
    arm_r == dwm_pkg::ARM_IDLE ##1 arm_r == dwm_pkg::ARM_READY |-> $past(low_cnt) >= dwm_pkg::DETECT_LOW_CYC;
  endproperty
  a_arm_time: assert property (p_arm_time) else $error("armed before low time elapsed");

  property p_detect;
    arm_r == dwm_pkg::ARM_READY && sense_s && active |=> det_r && pins_r.sample_cmd ##1 !det_r && per_cnt == 16'h0;
  endproperty
  a_detect: assert property (p_detect) else $error("detect pulse missing or wrong");

  property p_droop;
    active && droop_s |=> wake_r == dwm_pkg::WAKE_ACTIVE;
  endproperty
  a_droop: assert property (p_droop) else $error("droop did not enter wake mode");

  property p_wake_repeat;
    active && wake_r == dwm_pkg::WAKE_ACTIVE && !det_r && osc_wrap |=> osc_cnt == 10'h0;
  endproperty
  a_wake_repeat: assert property (p_wake_repeat) else $error("wake oscillator did not wrap");

  property p_wake_width;
    pins_r.wake_oe |-> wake_r == dwm_pkg::WAKE_ACTIVE && $past(osc_cnt) < dwm_pkg::WAKE_PULSE_CYC;
  endproperty
  a_wake_width: assert property (p_wake_width) else $error("wake pulse outside its window");

  property p_lockout;
    !active |=> !pins_r.wake_oe && !det_r && $stable(pins_r.ens_oe);
  endproperty
  a_lockout: assert property (p_lockout) else $error("activity during lockout");

  property p_no_arm_no_detect;
    arm_r == dwm_pkg::ARM_IDLE |=> !det_r && !pins_r.sample_cmd;
  endproperty
  a_no_arm_no_detect: assert property (p_no_arm_no_detect) else $error("detect without arming");

  property p_long_clear;
    det_r && !long_per |=> long_cnt == 6'h0;
  endproperty
  a_long_clear: assert property (p_long_clear) else $error("long count not cleared");

  c_detect: cover property (det_r ##[1:1000] det_r);
  c_wake_pulse: cover property ($rose(pins_r.wake_oe) ##[1:1000] $rose(pins_r.wake_oe));
  c_ens_pull: cover property ($rose(pins_r.ens_oe));
  c_ens_release: cover property ($fell(pins_r.ens_oe));
endmodule : dwm_ctrl

// ---- tb/dwm_flyback_model.sv ----
// behavioural primary-side flyback as seen through the secondary winding
`timescale 1ns/100ps
module dwm_flyback_model (
  input wire logic clk,
  input wire logic wake_oe,
  output logic wake_in
);
  logic wind_r = 1'b0;
  // wake switch shorts the winding while it is on
  assign wake_in = wind_r & ~wake_oe;
  // one power cycle: rise, high for hi cycles, low for the rest of the period
  // periods stay far below 40 ms so the held reference never goes stale
  task automatic power_cycle(input int period, input int hi);
    wind_r <= 1'b1;
    repeat (hi) @(posedge clk);
    wind_r <= 1'b0;
    repeat (period - hi) @(posedge clk);
  endtask : power_cycle
  // ringing edge followed by a low of lo cycles
  task automatic ring(input int lo);
    wind_r <= 1'b1;
    @(posedge clk);
    wind_r <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask : ring
endmodule : dwm_flyback_model

// ---- tb/dwm_ctrl_bench.sv ----
// self-checking bench for the droop wake monitor control logic
`timescale 1ns/100ps
module dwm_ctrl_bench;
  // short disable threshold keeps the long-period runs brief
  localparam logic [15:0] DIS = 16'h0064;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic droop_fired = 1'b0;
  logic supply_lockout = 1'b0;
  logic wake_in;
  logic ens_level;
  logic pulled = 1'b0;
  logic [15:0] lfsr = 16'h001b;
  dwm_pkg::dwm_pins_s pins;
  int num_errors = 0;
  int compares = 0;
  int n_samp = 0;
  int n_wake = 0;
  int exp_samp = 0;
  int long_c = 0;
  int short_c = 0;
  int prev_p = 30;
  int t;
  int t2;
  int n0;
  int n1;

  dwm_ctrl #(.DISABLE_PERIOD_CYC(DIS)) uut (.clk(clk), .rst_n(rst_n), .wake_in(wake_in),
    .droop_fired(droop_fired), .supply_lockout(supply_lockout), .pins(pins));
  dwm_flyback_model fly (.clk(clk), .wake_oe(pins.wake_oe), .wake_in(wake_in));
  // open drain with a pull-up; nothing outside pulls it below ground
  assign ens_level = pins.ens_oe ? pins.ens_out : 1'b1;

  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    n_samp <= n_samp + int'(pins.sample_cmd === 1'b1);
    n_wake <= n_wake + int'(pins.wake_oe === 1'b1);
  end

  function automatic int rnd(input int lo, input int span);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lo + int'(lfsr) % span;
  endfunction : rnd

  // expected pull state after a detect closing a period of p cycles
  function automatic logic ens_next(input int p);
    if (!pulled) begin
      long_c = (p > int'(DIS)) ? long_c + 1 : 0;
      if (long_c == 63) begin
        short_c = 0;
        return 1'b1;
      end
    end else begin
      short_c = short_c + int'(p < dwm_pkg::ENABLE_PERIOD_CYC_I);
      if (short_c == 32) begin
        long_c = 0;
        return 1'b0;
      end
    end
    return pulled;
  endfunction : ens_next

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int p);
    fly.power_cycle(p, 4);
    exp_samp++;
    pulled = ens_next(prev_p);
    prev_p = p;
    chk(ens_level, !pulled);
  endtask : cyc

  // negedge sampling keeps clear of the edge that updates the outputs
  task automatic wait_oe(input logic lvl, input int lim, output int n);
    n = 0;
    while (pins.wake_oe !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_oe

  task automatic end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    // 240 ns lows never arm, 800 ns lows always do
    fly.power_cycle(40, 4);
    fly.ring(6);
    fly.ring(6);
    fly.ring(20);
    fly.ring(20);
    repeat (5) @(posedge clk);
    chk(n_samp, 3);
    $display("test arming done");
    exp_samp = 3;
    // one cycle over the disable threshold counts long, the threshold itself does not
    for (int i = 0; i < 62; i++) cyc((i == 0) ? int'(DIS) + 1 : rnd(110, 16));
    cyc(int'(DIS));
    for (int i = 0; i < 63; i++) cyc(rnd(110, 16));
    cyc(120);
    // exact enable threshold is not short, one cycle less is
    for (int i = 0; i < 80 && pulled; i++) begin
      if (i < 2) cyc(dwm_pkg::ENABLE_PERIOD_CYC_I - i);
      else cyc((rnd(0, 4) == 0) ? rnd(1500, 30) : rnd(30, 60));
    end
    repeat (5) @(posedge clk);
    chk(n_samp, exp_samp);
    $display("test enable done");
    droop_fired <= 1'b1;
    wait_oe(1'b1, 10, t);
    chk(t < 10, 1);
    chk(pins.wake_out, 1'b0);
    wait_oe(1'b0, 40, t);
    chk(t, dwm_pkg::WAKE_PULSE_CYC_I);
    wait_oe(1'b1, 800, t2);
    chk(t + t2, dwm_pkg::WAKE_PERIOD_CYC_I);
    wait_oe(1'b0, 40, t);
    // droop still present at a detect: one fresh pulse right after it
    @(posedge clk);
    n0 = n_wake;
    fly.power_cycle(60, 4);
    chk(n_wake - n0, dwm_pkg::WAKE_PULSE_CYC_I);
    @(posedge clk);
    droop_fired <= 1'b0;
    @(posedge clk);
    fly.power_cycle(60, 4);
    n0 = n_wake;
    repeat (800) @(posedge clk);
    chk(n_wake - n0, 0);
    $display("test wake done");
    supply_lockout <= 1'b1;
    @(posedge clk);
    droop_fired <= 1'b1;
    n0 = n_wake;
    n1 = n_samp;
    repeat (3) fly.power_cycle(120, 4);
    repeat (800) @(posedge clk);
    chk(n_wake - n0, 0);
    chk(n_samp - n1, 0);
    chk(ens_level, !pulled);
    supply_lockout <= 1'b0;
    droop_fired <= 1'b0;
    repeat (30) @(posedge clk);
    fly.power_cycle(40, 4);
    repeat (5) @(posedge clk);
    chk(n_samp - n1, 1);
    $display("test lockout done");
    end_sim();
  end
endmodule : dwm_ctrl_bench
